// ---- logic/xcs_decode.sv ----
// x-bus chip select decode with apb configuration registers
// Operation
// - the address-20 mask output combines the keyboard controller gate with the fast_addr20_bit bit.
// - the firmware rom select is asserted for reads or writes to enabled firmware ranges.
// - the firmware rom select is decoded from system address 16:0 and latched address 23:17.
// - the firmware rom select is never asserted during dma cycles.
// - the keyboard controller select is asserted for i/o accesses to ports 60h and 64h.
// - the keyboard controller select pin can be turned into a general purpose output.
// - the microcontroller select is asserted for i/o accesses to ports 62h and 66h.
// - each programmable select goes low for pci-initiated isa i/o cycles in its range.
// - while a programmable select is active the x-bus buffer enable and direction are driven.
`timescale 1ns/10ps
`default_nettype none

module xcs_decode #(
    parameter int unsigned MASK_W = 8
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // apb slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // isa address and command pins
    input  wire logic [19:0] isa_system_address,
    input  wire logic [6:0]  isa_latched_address,
    input  wire logic        ior_n,
    input  wire logic        iow_n,
    input  wire logic        memr_n,
    input  wire logic        memw_n,
    input  wire logic        dma_cycle,
    input  wire logic        pci_master_cycle,
    input  wire logic        addr20_gate_in,
    // power management, same clock
    input  wire logic        power_on_suspend,
    // x-bus outputs, active low
    output logic             addr20_mask_out_n,
    output logic             firmware_rom_select_n,
    output logic             keyboard_ctrl_select_n,
    output logic             micro_ctrl_select_n,
    output logic             prog_select_zero_n,
    output logic             prog_select_one_n,
    output logic             xbus_buffer_output_enable_n,
    output logic             xbus_buffer_direction_n
);

    localparam int unsigned SYNC_W_L = xcs_pkg::SYNC_W;

    // configuration registers
    logic [31:0]               sysctl_q;
    logic [31:0]               xcfg_q;
    logic [31:0]               pcs_q [2];
    // apb read path
    logic [31:0]               rdata_q;
    logic                      slverr_q;
    logic [31:0]               rdata_d;
    logic                      mapped_d;
    logic                      wr_en;
    // pin synchroniser
    logic [SYNC_W_L-1:0]       sync_in;
    logic [SYNC_W_L-1:0]       sync1_q;
    logic [SYNC_W_L-1:0]       sync2_q;
    // decoded cycle
    logic [19:0]               sa;
    logic [6:0]                la;
    logic [23:0]               mem_addr;
    logic                      s_ior_n;
    logic                      s_iow_n;
    logic                      s_memr_n;
    logic                      s_memw_n;
    logic                      s_dma;
    logic                      s_pci;
    logic                      s_gate;
    xcs_pkg::xcs_cycle_e       cycle;
    // select next values and registers
    logic                      rom_d;
    logic                      kbc_d;
    logic                      mc_d;
    logic [1:0]                pcs_hit;
    logic [1:0]                pcs_d;
    logic                      a20_mask_q;
    logic                      rom_q;
    logic                      kbc_q;
    logic                      mc_q;
    logic [1:0]                pcs_sel_q;
    logic                      xoe_q;
    logic                      xbus_buffer_direction_q;

    // ---------------- apb slave ----------------

    // zero wait states: read data is captured in the setup cycle
    assign pready  = 1'b1;
    assign prdata  = rdata_q;
    assign pslverr = slverr_q;
    assign wr_en   = psel & penable & pwrite & ~slverr_q;

    // read mux and address decode
    always_comb begin
        rdata_d  = 32'h0000_0000;
        mapped_d = 1'b1;
        if (paddr == xcs_pkg::SYSCTL_OFF) begin
            rdata_d = sysctl_q;
        end else if (paddr == xcs_pkg::XCFG_OFF) begin
            rdata_d = xcfg_q;
        end else if (paddr == xcs_pkg::PROG_SELECT_ZERO_OFF) begin
            rdata_d = pcs_q[0];
        end else if (paddr == xcs_pkg::PROG_SELECT_ONE_OFF) begin
            rdata_d = pcs_q[1];
        end else if (paddr == xcs_pkg::STATUS_OFF) begin
            // live pin state as driven, so software sees the block's own decode
            rdata_d = {24'h00_0000, xbus_buffer_direction_q, xoe_q, pcs_sel_q, mc_q, kbc_q, rom_q, a20_mask_q};
        end else begin
            mapped_d = 1'b0;
        end
    end

    // setup cycle latches read data and the error answer for the access phase
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q  <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (psel && !penable) begin
            rdata_q  <= pwrite ? 32'h0000_0000 : rdata_d;
            slverr_q <= ~mapped_d;
        end
    end

    // system control port: only the fast_addr20_bit bit is implemented
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sysctl_q <= xcs_pkg::SYSCTL_RST;
        end else if (wr_en && paddr == xcs_pkg::SYSCTL_OFF) begin
            sysctl_q <= {30'h0000_0000, pwdata[xcs_pkg::FAST_ADDR20_BIT_BIT], 1'b0};
        end
    end

    // x-bus configuration: rom windows, rom write enable, gpo mode and value
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            xcfg_q <= xcs_pkg::XCFG_RST;
        end else if (wr_en && paddr == xcs_pkg::XCFG_OFF) begin
            xcfg_q <= {26'h000_0000, pwdata[5:0]};
        end
    end

    // programmable range registers, one per select
    for (genvar i = 0; i < 2; i++) begin : g_pcs_reg
        localparam logic [7:0] OFF = (i == 0) ? xcs_pkg::PROG_SELECT_ZERO_OFF : xcs_pkg::PROG_SELECT_ONE_OFF;
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                pcs_q[i] <= xcs_pkg::PCS_RST;
            end else if (wr_en && paddr == OFF) begin
                pcs_q[i] <= {7'h00, pwdata[24:0]};
            end
        end
    end

    // ---------------- pin synchroniser ----------------

    assign sync_in = {isa_system_address, isa_latched_address,
                      ior_n, iow_n, memr_n, memw_n,
                      dma_cycle, pci_master_cycle, addr20_gate_in};

    // two flops; strobes idle high so they reset high, costing two cycles of latency
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= {27'h000_0000, 4'hf, 3'h0};
            sync2_q <= {27'h000_0000, 4'hf, 3'h0};
        end else begin
            sync1_q <= sync_in;
            sync2_q <= sync1_q;
        end
    end

    assign sa       = sync2_q[33:14];
    assign la       = sync2_q[13:7];
    assign s_ior_n  = sync2_q[6];
    assign s_iow_n  = sync2_q[5];
    assign s_memr_n = sync2_q[4];
    assign s_memw_n = sync2_q[3];
    assign s_dma    = sync2_q[2];
    assign s_pci    = sync2_q[1];
    assign s_gate   = sync2_q[0];
    assign mem_addr = {la, sa[16:0]};

    // classify the current isa command; i/o wins if strobes ever overlap
    always_comb begin
        if (!s_ior_n) begin
            cycle = xcs_pkg::CYC_IO_RD;
        end else if (!s_iow_n) begin
            cycle = xcs_pkg::CYC_IO_WR;
        end else if (!s_memr_n) begin
            cycle = xcs_pkg::CYC_MEM_RD;
        end else if (!s_memw_n) begin
            cycle = xcs_pkg::CYC_MEM_WR;
        end else begin
            cycle = xcs_pkg::CYC_IDLE;
        end
    end

    // ---------------- select decode ----------------

    // firmware rom: enabled windows only, writes only when allowed, never for dma
    always_comb begin
        logic win;
        logic cmd;
        win = (xcfg_q[xcs_pkg::ROM_FSEG_BIT] && mem_addr[23:16] == xcs_pkg::ROM_FSEG_HI)
            | (xcfg_q[xcs_pkg::ROM_ESEG_BIT] && mem_addr[23:16] == xcs_pkg::ROM_ESEG_HI)
            | (xcfg_q[xcs_pkg::ROM_TOP_BIT]  && la == xcs_pkg::ROM_TOP_HI);
        cmd = (cycle == xcs_pkg::CYC_MEM_RD)
            | ((cycle == xcs_pkg::CYC_MEM_WR) & xcfg_q[xcs_pkg::ROM_WR_BIT]);
        rom_d = win & cmd & ~s_dma;
    end

    // fixed i/o selects; for i/o cycles only sa[15:0] carry a defined address
    always_comb begin
        logic io;
        io    = (cycle == xcs_pkg::CYC_IO_RD) | (cycle == xcs_pkg::CYC_IO_WR);
        kbc_d = io & ((sa[15:0] == xcs_pkg::KBC_DATA_IO)
                    | (sa[15:0] == xcs_pkg::KBC_CMD_IO));
        mc_d  = io & ((sa[15:0] == xcs_pkg::MC_DATA_IO)
                    | (sa[15:0] == xcs_pkg::MC_CMD_IO));
    end

    // programmable ranges, each qualified by a pci-initiated i/o cycle
    for (genvar i = 0; i < 2; i++) begin : g_pcs
        xcs_io_range #(
            .MASK_W (MASK_W)
        ) u_range (
            .io_addr (sa[15:0]),
            .base    (pcs_q[i][xcs_pkg::PCS_BASE_LSB +: 16]),
            .mask    (pcs_q[i][xcs_pkg::PCS_MASK_LSB +: MASK_W]),
            .enable  (pcs_q[i][xcs_pkg::PCS_EN_BIT]),
            .hit     (pcs_hit[i])
        );
        assign pcs_d[i] = pcs_hit[i] & s_pci & ~s_dma
                        & ((cycle == xcs_pkg::CYC_IO_RD) | (cycle == xcs_pkg::CYC_IO_WR));
    end

    // ---------------- output registers ----------------

    // address-20 mask is inactive while either source enables a20
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            a20_mask_q <= 1'b0;
        end else begin
            a20_mask_q <= s_gate | sysctl_q[xcs_pkg::FAST_ADDR20_BIT_BIT];
        end
    end

    // chip selects held high in reset, and in suspend except the kbc pin in gpo mode, which keeps its gpo value
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rom_q     <= 1'b1;
            kbc_q     <= 1'b1;
            mc_q      <= 1'b1;
            pcs_sel_q <= 2'b11;
        end else if (power_on_suspend) begin
            rom_q     <= 1'b1;
            kbc_q     <= xcfg_q[xcs_pkg::KBC_GPO_BIT] ? xcfg_q[xcs_pkg::GENERAL_OUTPUT_TWENTY_SIX_BIT] : 1'b1;
            mc_q      <= 1'b1;
            pcs_sel_q <= 2'b11;
        end else begin
            rom_q     <= ~rom_d;
            // gpo mode hands the pin to software
            kbc_q     <= xcfg_q[xcs_pkg::KBC_GPO_BIT] ? xcfg_q[xcs_pkg::GENERAL_OUTPUT_TWENTY_SIX_BIT] : ~kbc_d;
            mc_q      <= ~mc_d;
            pcs_sel_q <= ~pcs_d;
        end
    end

    // buffer controls follow the programmable selects in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            xoe_q  <= 1'b1;
            xbus_buffer_direction_q <= 1'b1;
        end else if (power_on_suspend) begin
            xoe_q  <= 1'b1;
            xbus_buffer_direction_q <= 1'b1;
        end else begin
            xoe_q  <= ~(|pcs_d);
            xbus_buffer_direction_q <= ~((|pcs_d) & (cycle == xcs_pkg::CYC_IO_RD));
        end
    end

    assign addr20_mask_out_n           = a20_mask_q;
    assign firmware_rom_select_n       = rom_q;
    assign keyboard_ctrl_select_n      = kbc_q;
    assign micro_ctrl_select_n         = mc_q;
    assign prog_select_zero_n          = pcs_sel_q[0];
    assign prog_select_one_n           = pcs_sel_q[1];
    assign xbus_buffer_output_enable_n = xoe_q;
    assign xbus_buffer_direction_n     = xbus_buffer_direction_q;

endmodule

`default_nettype wire

// ---- logic/xcs_io_range.sv ----
// one programmable i/o range comparator
`timescale 1ns/10ps
`default_nettype none

module xcs_io_range #(
    parameter int unsigned MASK_W = 8
) (
    // address under test
    input  wire logic [15:0]       io_addr,
    // programmed window
    input  wire logic [15:0]       base,
    input  wire logic [MASK_W-1:0] mask,
    input  wire logic              enable,
    // result
    output logic                   hit
);

    logic [15:0] care;

    // mask bits mark low address bits that do not take part in the compare
    assign care = ~{{(16 - MASK_W){1'b0}}, mask};
    assign hit  = enable & (((io_addr ^ base) & care) == 16'h0000);

endmodule

`default_nettype wire

// ---- logic/xcs_pkg.sv ----
// constants for the x-bus chip select decode block
package xcs_pkg;

    // apb register byte offsets
    localparam logic [7:0]  SYSCTL_OFF   = 8'h00;
    localparam logic [7:0]  XCFG_OFF     = 8'h04;
    localparam logic [7:0]  PROG_SELECT_ZERO_OFF     = 8'h08;
    localparam logic [7:0]  PROG_SELECT_ONE_OFF     = 8'h0c;
    localparam logic [7:0]  STATUS_OFF   = 8'h10;

    // system control port fields
    localparam int unsigned FAST_ADDR20_BIT_BIT = 1;

    // x-bus configuration fields
    localparam int unsigned ROM_FSEG_BIT = 0;
    localparam int unsigned ROM_ESEG_BIT = 1;
    localparam int unsigned ROM_TOP_BIT  = 2;
    localparam int unsigned ROM_WR_BIT   = 3;
    localparam int unsigned KBC_GPO_BIT  = 4;
    localparam int unsigned GENERAL_OUTPUT_TWENTY_SIX_BIT    = 5;

    // programmable range fields
    localparam int unsigned PCS_BASE_LSB = 0;
    localparam int unsigned PCS_MASK_LSB = 16;
    localparam int unsigned PCS_EN_BIT   = 24;

    // values after reset
    localparam logic [31:0] SYSCTL_RST   = 32'h0000_0000;
    localparam logic [31:0] XCFG_RST     = 32'h0000_0005;
    localparam logic [31:0] PCS_RST      = 32'h0000_0000;

    // fixed i/o ports
    localparam logic [15:0] KBC_DATA_IO  = 16'h0060;
    localparam logic [15:0] KBC_CMD_IO   = 16'h0064;
    localparam logic [15:0] MC_DATA_IO   = 16'h0062;
    localparam logic [15:0] MC_CMD_IO    = 16'h0066;

    // firmware memory windows, upper address bits
    localparam logic [7:0]  ROM_FSEG_HI  = 8'h0f;
    localparam logic [7:0]  ROM_ESEG_HI  = 8'h0e;
    localparam logic [6:0]  ROM_TOP_HI   = 7'h7f;

    // synchroniser width: 20 sa + 7 la + 4 strobes + 3 levels
    localparam int unsigned SYNC_W       = 34;

    // isa cycle kind, one-hot
    typedef enum logic [4:0] {
        CYC_IDLE   = 5'b00001,
        CYC_IO_RD  = 5'b00010,
        CYC_IO_WR  = 5'b00100,
        CYC_MEM_RD = 5'b01000,
        CYC_MEM_WR = 5'b10000
    } xcs_cycle_e;

endpackage

// ---- verif/tb.sv ----
// testbench for the x-bus chip select decode
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam logic [3:0]  IOR = 4'h7, IOW = 4'hb, MR = 4'hd, MW = 4'he;
    localparam logic [15:0] IO_PT [6] = '{16'h0060, 16'h0064, 16'h0062, 16'h0066,
                                          16'h0061, 16'h0063};
    localparam logic [6:0]  IO_EX [6] = '{7'h20, 7'h20, 7'h10, 7'h10, 7'h00, 7'h00};
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr, clr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [19:0] sa;
    logic [6:0]  la;
    logic        ior_n, iow_n, memr_n, memw_n, dma, pci, gate, pos;
    logic        a20_n, rom_n, kbc_n, mc_n, p0_n, p1_n, oe_n, dir_n;
    logic [4:0]  seen;
    int          fail_count, compares;
    // 100 mhz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    xcs_decode u_dut (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .isa_system_address(sa), .isa_latched_address(la), .ior_n(ior_n), .iow_n(iow_n),
        .memr_n(memr_n), .memw_n(memw_n), .dma_cycle(dma), .pci_master_cycle(pci),
        .addr20_gate_in(gate), .power_on_suspend(pos), .addr20_mask_out_n(a20_n),
        .firmware_rom_select_n(rom_n), .keyboard_ctrl_select_n(kbc_n),
        .micro_ctrl_select_n(mc_n), .prog_select_zero_n(p0_n), .prog_select_one_n(p1_n),
        .xbus_buffer_output_enable_n(oe_n), .xbus_buffer_direction_n(dir_n));
    xcs_xbus_model u_xb (.clk(clk), .rstn(rstn), .sel_n({rom_n, kbc_n, mc_n, p0_n, p1_n}),
        .clr(clr), .seen(seen));
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic stop_test;
        if (fail_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one apb transfer; waits for pready whatever the latency, the watchdog bounds it
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so a following call never re-drives psel in this time step
        @(posedge clk);
    endtask
    // one isa cycle: clear the log, drive, let it cross the sync, judge, go idle
    task automatic cyc(input logic [19:0] a, input logic [6:0] l, input logic [3:0] st,
                       input logic d, input logic p, input logic [6:0] e);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        sa <= a;
        la <= l;
        {ior_n, iow_n, memr_n, memw_n} <= st;
        dma <= d;
        pci <= p;
        repeat (5) @(posedge clk);
        chk({~rom_n, ~kbc_n, ~mc_n, ~p0_n, ~p1_n, ~oe_n, ~dir_n} === e, $sformatf("sel %h", a));
        chk(seen === e[6:2], $sformatf("stray select %h", a));
        {ior_n, iow_n, memr_n, memw_n} <= 4'hf;
        dma <= 1'b0;
        pci <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
    task automatic t_a20;
        apb(xcs_pkg::SYSCTL_OFF, 1'b1, 32'h1 << xcs_pkg::FAST_ADDR20_BIT_BIT);
        repeat (2) @(posedge clk);
        chk(a20_n === 1'b1, "fast bit ignored");
        apb(xcs_pkg::SYSCTL_OFF, 1'b1, 32'h0);
        repeat (2) @(posedge clk);
        chk(a20_n === 1'b0, "mask stuck");
        gate <= 1'b1;
        repeat (5) @(posedge clk);
        chk(a20_n === 1'b1, "gate ignored");
        gate <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
    task automatic t_io;
        for (int i = 0; i < 12; i++)
            cyc({4'h0, IO_PT[i/2]}, 7'h00, i[0] ? IOW : IOR, 1'b0, 1'b0, IO_EX[i/2]);
        cyc(20'h00060, 7'h00, MR, 1'b0, 1'b0, 7'h00);
    endtask
    task automatic t_rom;
        cyc(20'hf0000, 7'h07, MR, 1'b0, 1'b0, 7'h40);
        cyc(20'he0000, 7'h07, MR, 1'b0, 1'b0, 7'h00);
        cyc(20'hf0000, 7'h7f, MR, 1'b0, 1'b0, 7'h40);
        cyc(20'hf0000, 7'h17, MR, 1'b0, 1'b0, 7'h00);
        cyc(20'hf0000, 7'h07, IOR, 1'b0, 1'b0, 7'h00);
        cyc(20'hf0000, 7'h07, MW, 1'b0, 1'b0, 7'h00);
        apb(xcs_pkg::XCFG_OFF, 1'b1, 32'hf);
        cyc(20'he0000, 7'h07, MR, 1'b0, 1'b0, 7'h40);
        cyc(20'hf0000, 7'h07, MW, 1'b0, 1'b0, 7'h40);
        cyc(20'hf0000, 7'h07, MR, 1'b1, 1'b0, 7'h00);
        apb(xcs_pkg::XCFG_OFF, 1'b1, xcs_pkg::XCFG_RST);
    endtask
    task automatic t_gpo;
        apb(xcs_pkg::XCFG_OFF, 1'b1, 32'h15);
        repeat (2) @(posedge clk);
        chk(kbc_n === 1'b0, "gpo low not driven");
        apb(xcs_pkg::XCFG_OFF, 1'b1, 32'h35);
        repeat (2) @(posedge clk);
        chk(kbc_n === 1'b1, "gpo high not driven");
        apb(xcs_pkg::XCFG_OFF, 1'b1, xcs_pkg::XCFG_RST);
    endtask
    task automatic t_pcs;
        apb(xcs_pkg::PROG_SELECT_ZERO_OFF, 1'b1, 32'h0100_0300);
        apb(xcs_pkg::PROG_SELECT_ONE_OFF, 1'b1, 32'h010f_0310);
        cyc(20'h00300, 7'h00, IOR, 1'b0, 1'b1, 7'h0b);
        cyc(20'h00300, 7'h00, IOW, 1'b0, 1'b1, 7'h0a);
        cyc(20'h00300, 7'h00, IOR, 1'b0, 1'b0, 7'h00);
        cyc(20'h00300, 7'h00, IOR, 1'b1, 1'b1, 7'h00);
        cyc(20'h0031c, 7'h00, IOR, 1'b0, 1'b1, 7'h07);
        cyc(20'h00320, 7'h00, IOR, 1'b0, 1'b1, 7'h00);
    endtask
    task automatic t_pos;
        pos <= 1'b1;
        cyc(20'h00060, 7'h00, IOR, 1'b0, 1'b0, 7'h00);
        cyc(20'hf0000, 7'h07, MR, 1'b0, 1'b0, 7'h00);
        cyc(20'h00300, 7'h00, IOR, 1'b0, 1'b1, 7'h00);
        pos <= 1'b0;
    endtask
    task automatic t_rst;
        sa <= 20'h00064;
        ior_n <= 1'b0;
        repeat (5) @(posedge clk);
        chk(kbc_n === 1'b0, "kbc select missing");
        rstn <= 1'b0;
        @(posedge clk);
        ior_n <= 1'b1;
        @(posedge clk);
        chk({rom_n, kbc_n, mc_n, p0_n, p1_n, oe_n} === 6'h3f, "select in reset");
        rstn <= 1'b1;
        @(posedge clk);
        chk({rom_n, kbc_n, mc_n, p0_n, p1_n, oe_n} === 6'h3f, "select after reset");
        apb(xcs_pkg::XCFG_OFF, 1'b0, 32'h0);
        chk(rd === xcs_pkg::XCFG_RST, "config not reset");
        apb(xcs_pkg::STATUS_OFF, 1'b0, 32'h0);
        chk(rd === 32'h0000_00fe && err === 1'b0, "status not idle");
        apb(8'h14, 1'b0, 32'h0);
        chk(err === 1'b1, "unmapped read accepted");
    endtask
    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        stop_test;
    end
    // reset, then each scenario in turn
    initial begin
        {rstn, psel, penable, pwrite, clr, dma, pci, gate, pos} = 9'h0;
        {ior_n, iow_n, memr_n, memw_n} = 4'hf;
        {paddr, pwdata, sa, la} = '0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk(a20_n === 1'b0 && rom_n === 1'b1 && kbc_n === 1'b1, "reset outputs");
        t_a20;
        t_io;
        t_rom;
        t_gpo;
        t_pcs;
        t_pos;
        t_rst;
        stop_test;
    end
endmodule
`default_nettype wire

// ---- verif/xcs_decode_asserts.sv ----
// assertions on the ports of the x-bus chip select decode
`timescale 1ns/10ps
`default_nettype none
module xcs_decode_chk (
    // clock, reset and isa pins
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [19:0] isa_system_address,
    input wire logic        ior_n,
    input wire logic        dma_cycle,
    input wire logic        pci_master_cycle,
    input wire logic        addr20_gate_in,
    input wire logic        power_on_suspend,
    // x-bus outputs
    input wire logic        addr20_mask_out_n,
    input wire logic        firmware_rom_select_n,
    input wire logic        keyboard_ctrl_select_n,
    input wire logic        micro_ctrl_select_n,
    input wire logic        prog_select_zero_n,
    input wire logic        prog_select_one_n,
    input wire logic        xbus_buffer_output_enable_n
);
    logic [1:0] up_q;
    logic       up;
    logic       pcs;
    // edges since reset; three-deep history must not reach back into reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            up_q <= 2'h0;
        else if (up_q != 2'h3)
            up_q <= up_q + 2'h1;
    end
    assign up = (up_q == 2'h3);
    assign pcs = !prog_select_zero_n || !prog_select_one_n;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // pins take three edges to reach the outputs: two sync flops and the output flop
    property p_a20;
        up && $past(addr20_gate_in, 3) |-> addr20_mask_out_n;
    endproperty
    a_a20: assert property (p_a20) else $error("a20 masked with gate high");
    property p_rom_dma;
        up && !firmware_rom_select_n |-> !$past(dma_cycle, 3);
    endproperty
    a_rom_dma: assert property (p_rom_dma) else $error("rom select in dma");
    property p_mc_hit;
        up && !power_on_suspend && !$past(power_on_suspend) && !$past(ior_n, 3)
            && (($past(isa_system_address, 3) & 20'h0fffb) == 20'h00062)
            |-> !micro_ctrl_select_n;
    endproperty
    a_mc_hit: assert property (p_mc_hit) else $error("micro select missing");
    property p_mc_miss;
        up && !micro_ctrl_select_n
            |-> (($past(isa_system_address, 3) & 20'h0fffb) == 20'h00062);
    endproperty
    a_mc_miss: assert property (p_mc_miss) else $error("micro select stray");
    property p_kbc_hit;
        up && !power_on_suspend && !$past(power_on_suspend) && !$past(ior_n, 3)
            && (($past(isa_system_address, 3) & 20'h0fffb) == 20'h00060)
            |-> !keyboard_ctrl_select_n;
    endproperty
    a_kbc_hit: assert property (p_kbc_hit) else $error("kbc select missing");
    property p_pcs_src;
        up && pcs |-> $past(pci_master_cycle, 3) && !$past(dma_cycle, 3);
    endproperty
    a_pcs_src: assert property (p_pcs_src) else $error("prog select not pci");
    property p_xoe;
        pcs |-> !xbus_buffer_output_enable_n;
    endproperty
    a_xoe: assert property (p_xoe) else $error("buffer off with prog select");
    property p_pos;
        power_on_suspend && $past(power_on_suspend) |-> firmware_rom_select_n
            && micro_ctrl_select_n && !pcs;
    endproperty
    a_pos: assert property (p_pos) else $error("select active in suspend");
    property p_rel;
        $rose(rstn) |-> firmware_rom_select_n && keyboard_ctrl_select_n
            && micro_ctrl_select_n && !pcs && xbus_buffer_output_enable_n;
    endproperty
    a_rel: assert property (p_rel) else $error("select active after reset");
    c_rom: cover property (!firmware_rom_select_n);
    c_kbc: cover property (!keyboard_ctrl_select_n);
    c_pcs: cover property (!prog_select_one_n);
endmodule
bind xcs_decode xcs_decode_chk u_chk (.clk, .rstn, .isa_system_address, .ior_n, .dma_cycle,
    .pci_master_cycle, .addr20_gate_in, .power_on_suspend, .addr20_mask_out_n,
    .firmware_rom_select_n, .keyboard_ctrl_select_n, .micro_ctrl_select_n,
    .prog_select_zero_n, .prog_select_one_n, .xbus_buffer_output_enable_n);
`default_nettype wire

// ---- verif/xcs_xbus_model.sv ----
// x-bus peripherals: log of which selects they saw
`timescale 1ns/10ps
`default_nettype none
module xcs_xbus_model (
    // clock and reset
    input wire logic       clk,
    input wire logic       rstn,
    // selects, log clear and log
    input wire logic [4:0] sel_n,
    input wire logic       clr,
    output logic [4:0]     seen
);
    // sticky, so a one-cycle glitch on any select is never lost
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            seen <= 5'h00;
        else if (clr)
            seen <= 5'h00;
        else
            seen <= seen | ~sel_n;
    end
endmodule
`default_nettype wire
